// file: pkg/doc_defines.vh
`ifndef DOC_DEFINES_VH
`define DOC_DEFINES_VH

// ****************************************
// timing
// ****************************************
`define DOC_CLK_HZ 20000000
`define DOC_MASTER_HZ 1000000
`define DOC_MASTER_HALF_CLKS (`DOC_CLK_HZ / `DOC_MASTER_HZ / 2)
`define DOC_STARTUP_MASTER 500
`define DOC_FILT_SCALE 16
`define DOC_FILT_OFFSET 6

// ****************************************
// quantizer and code fields
// ****************************************
`define DOC_SAMPLE_W 8
`define DOC_CODE_W 4
`define DOC_FLOAT_BIT 3
`define DOC_EXP_W 3
`define DOC_RATIO_W 8
`define DOC_FIRST_LOW_HALVES 8'h02
`define DOC_SMALL_RATIO 8'h04

// ****************************************
// register map
// ****************************************
`define DOC_ADDR_W 8
`define DOC_REG_CTRL 8'h00
`define DOC_REG_STATUS 8'h04
`define DOC_REG_RATIO 8'h08
`define DOC_CTRL_RESET 1'b0
`define DOC_CTRL_FORCE_DIS 0
`define DOC_ST_FLOAT 4
`define DOC_ST_STARTED 5
`define DOC_ST_ENABLED 6
`define DOC_ST_LEVEL 7
`define DOC_ST_CAND_LSB 8
`define DOC_ST_PENDING 12

`endif

// file: design/doc_osc_out.v
// Behaviour
// - 4-bit divider select code comes from quantized divider pin level.
// - code msb set floats disabled output; clear drives it low.
// - output is master frequency divided by 1,2,4,...,128.
// - codes 0-7 ascend 1..128 no float; 8-15 descend 128..1 float.
// - sixteen equal bands of pin-to-supply ratio, centre (code+0.5)/16.
// - enable low disables output at once, low or floated by float bit.
// - enable rise holds output low until aligned with the oscillator.
// - start-up waits for a stable code before enabling output.
// - master at most 1 MHz; output equals master over ratio.
// - enable delay within one output period (ratio<=2), else two master.
// - later code changes filtered, 16*(diff+6) master periods, glitch-free.
// - output floats for 500 master periods after reset.
// - after start-up, first low lasts one master (half output if ratio<4).
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "doc_defines.vh"

module doc_osc_out #(
  parameter STARTUP_MASTER = `DOC_STARTUP_MASTER,
  parameter MASTER_HALF_CLKS = `DOC_MASTER_HALF_CLKS
) (
  input wire clk, // 20 MHz system clock
  input wire reset, // synchronous, active high
  input wire ce, // clock enable, freezes all state when low
  input wire [`DOC_SAMPLE_W-1:0] div_sample, // pin level as fraction of supply
  input wire oe_pin, // output enable pin, high enables
  output wire out_o, // oscillator output level
  output wire out_oe_n, // output driver enable, low drives pin
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb write
  input wire [`DOC_ADDR_W-1:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr // apb error on unmapped address
);

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [`DOC_SAMPLE_W-1:0] samp_m_r;
  reg [`DOC_SAMPLE_W-1:0] samp_s_r;
  reg oe_m_r;
  reg oe_s_r;

  always @(posedge clk) begin
    if (reset) begin
      samp_m_r <= 8'h00;
      samp_s_r <= 8'h00;
      oe_m_r <= 1'b0;
      oe_s_r <= 1'b0;
    end else if (ce) begin
      samp_m_r <= div_sample;
      samp_s_r <= samp_m_r;
      oe_m_r <= oe_pin;
      oe_s_r <= oe_m_r;
    end
  end

  // equal bands: top four bits of the ratio pick the band
  wire [`DOC_CODE_W-1:0] raw_code =
    samp_s_r[`DOC_SAMPLE_W-1:`DOC_SAMPLE_W-`DOC_CODE_W];

  // ****************************************
  // half master period tick
  // ****************************************
  reg [7:0] half_cnt_r;
  wire half_tick = (half_cnt_r == MASTER_HALF_CLKS[7:0] - 8'h01);
  reg master_ph_r; // toggles each half tick; master tick on its fall

  always @(posedge clk) begin
    if (reset) begin
      half_cnt_r <= 8'h00;
      master_ph_r <= 1'b0;
    end else if (ce) begin
      if (half_tick) begin
        half_cnt_r <= 8'h00;
        master_ph_r <= ~master_ph_r;
      end else begin
        half_cnt_r <= half_cnt_r + 8'h01;
      end
    end
  end

  wire master_tick = half_tick & master_ph_r;

  // ****************************************
  // code filter and start-up
  // ****************************************
  reg [`DOC_CODE_W-1:0] code_r; // active divider select code
  reg [`DOC_CODE_W-1:0] cand_r;
  reg [8:0] stable_cnt_r;
  reg [9:0] start_cnt_r;
  reg started_r;
  reg ctrl_force_dis_r;

  wire [`DOC_CODE_W-1:0] code_diff = (cand_r > code_r) ?
    cand_r - code_r : code_r - cand_r;
  // sum fits five bits (15 + 6), times sixteen is a plain shift into nine
  wire [4:0] filt_sum = {1'b0, code_diff} + `DOC_FILT_OFFSET;
  wire [8:0] filt_need = {filt_sum, 4'h0};
  // at start-up a short stability window is enough: no old code to compare
  wire cand_stable = started_r ? (stable_cnt_r >= filt_need)
    : (stable_cnt_r >= `DOC_FILT_SCALE);
  wire pending = (cand_r != code_r);
  wire start_done = (start_cnt_r >= STARTUP_MASTER[9:0]);

  always @(posedge clk) begin
    if (reset) begin
      cand_r <= 4'h0;
      code_r <= 4'h0;
      stable_cnt_r <= 9'h000;
      start_cnt_r <= 10'h000;
      started_r <= 1'b0;
    end else if (ce && master_tick) begin
      if (raw_code != cand_r) begin
        cand_r <= raw_code; // restart: intermediate codes never apply
        stable_cnt_r <= 9'h000;
      end else if (!cand_stable) begin
        stable_cnt_r <= stable_cnt_r + 9'h001;
      end
      if (!start_done)
        start_cnt_r <= start_cnt_r + 10'h001;
      if (!started_r) begin
        if (start_done && cand_stable && raw_code == cand_r) begin
          code_r <= cand_r;
          started_r <= 1'b1;
        end
      end else if (pending && cand_stable && raw_code == cand_r) begin
        code_r <= cand_r;
      end
    end
  end

  // ****************************************
  // code decode
  // ****************************************
  wire float_bit = code_r[`DOC_FLOAT_BIT];
  // ratio table is symmetric about the code midpoint
  reg [`DOC_RATIO_W-1:0] ratio;
  always @* begin
    case (code_r)
      4'h0: ratio = 8'h01;
      4'h1: ratio = 8'h02;
      4'h2: ratio = 8'h04;
      4'h3: ratio = 8'h08;
      4'h4: ratio = 8'h10;
      4'h5: ratio = 8'h20;
      4'h6: ratio = 8'h40;
      4'h7: ratio = 8'h80;
      4'h8: ratio = 8'h80;
      4'h9: ratio = 8'h40;
      4'ha: ratio = 8'h20;
      4'hb: ratio = 8'h10;
      4'hc: ratio = 8'h08;
      4'hd: ratio = 8'h04;
      4'he: ratio = 8'h02;
      4'hf: ratio = 8'h01;
      default: ratio = 8'h01;
    endcase
  end

  // ****************************************
  // enable and divider
  // ****************************************
  // sync enable restarts phase; raw pin kills output without a clock
  wire en_sync = oe_s_r & started_r & ~ctrl_force_dis_r;
  wire drive_en = en_sync & oe_pin;

  reg [`DOC_RATIO_W-1:0] div_cnt_r;
  reg level_r;
  reg first_r; // first low phase after enable or start-up

  wire [`DOC_RATIO_W-1:0] first_len = (ratio < `DOC_SMALL_RATIO) ?
    ratio : `DOC_FIRST_LOW_HALVES;
  wire [`DOC_RATIO_W-1:0] half_len = first_r ? first_len : ratio;
  // compare with >= so a ratio drop mid-phase ends it cleanly
  wire phase_end = (div_cnt_r >= half_len - 8'h01);

  always @(posedge clk) begin
    if (reset) begin
      div_cnt_r <= 8'h00;
      level_r <= 1'b0;
      first_r <= 1'b1;
    end else if (ce) begin
      if (!en_sync) begin
        div_cnt_r <= 8'h00; // hold low, re-align on next enable
        level_r <= 1'b0;
        first_r <= 1'b1;
      end else if (half_tick) begin
        if (phase_end) begin
          div_cnt_r <= 8'h00;
          level_r <= ~level_r;
          first_r <= 1'b0;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end

  assign out_o = level_r & drive_en;
  // floated during start-up, else driven unless disabled with float set
  assign out_oe_n = ~started_r | (~drive_en & float_bit);

  // ****************************************
  // apb slave
  // ****************************************
  wire setup = psel & ~penable;
  wire mapped = (paddr == `DOC_REG_CTRL) | (paddr == `DOC_REG_STATUS) |
    (paddr == `DOC_REG_RATIO);
  assign pready = psel & penable & ce;
  assign pslverr = pready & ~mapped;

  always @(posedge clk) begin
    if (reset) begin
      ctrl_force_dis_r <= `DOC_CTRL_RESET;
    end else if (ce && pready && pwrite && paddr == `DOC_REG_CTRL) begin
      ctrl_force_dis_r <= pwdata[`DOC_CTRL_FORCE_DIS];
    end
  end

  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `DOC_REG_CTRL: rd_nxt[`DOC_CTRL_FORCE_DIS] = ctrl_force_dis_r;
      `DOC_REG_STATUS: begin
        rd_nxt[`DOC_CODE_W-1:0] = code_r;
        rd_nxt[`DOC_ST_FLOAT] = float_bit;
        rd_nxt[`DOC_ST_STARTED] = started_r;
        rd_nxt[`DOC_ST_ENABLED] = drive_en;
        rd_nxt[`DOC_ST_LEVEL] = out_o;
        rd_nxt[`DOC_ST_CAND_LSB+`DOC_CODE_W-1:`DOC_ST_CAND_LSB] = cand_r;
        rd_nxt[`DOC_ST_PENDING] = pending;
      end
      `DOC_REG_RATIO: rd_nxt[`DOC_RATIO_W-1:0] = ratio;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (ce && setup) begin
      prdata <= rd_nxt;
    end
  end

endmodule // doc_osc_out

// file: tb/doc_osc_out_properties.sv
`timescale 1ns/1ps
module doc_osc_props (
  input wire clk, // clock
  input wire reset, // sync reset
  input wire ce, // clock enable
  input wire oe_pin, // enable pin
  input wire out_o, // output level
  input wire out_oe_n, // driver off
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire [7:0] paddr, // apb address
  input wire pready, // apb ready
  input wire pslverr // apb error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_ready_access: assert property (pready == (psel && penable && ce))
    else $error("pready mismatch");
  a_error_unmapped: assert property (pslverr == (pready &&
    paddr != 8'h00 && paddr != 8'h04 && paddr != 8'h08))
    else $error("pslverr mismatch");
  a_disable_now: assert property (!oe_pin |-> !out_o)
    else $error("output active while disabled");
  a_reset_float: assert property ($fell(reset) |-> out_oe_n && !out_o)
    else $error("output driven after reset");
  a_high_half: assert property ($rose(out_o) |=> out_o || !oe_pin)
    else $error("high half too short");
  a_low_half: assert property ($fell(out_o) && oe_pin |=> !out_o)
    else $error("low half too short");
  a_enable_sync: assert property ($rose(oe_pin) |-> !out_o [*2])
    else $error("sliver after enable");
  a_first_low: assert property ($fell(out_oe_n) && oe_pin |-> !out_o [*2])
    else $error("first low phase missing");
endmodule // doc_osc_props
bind doc_osc_out doc_osc_props u_doc_osc_props (.clk, .reset, .ce, .oe_pin,
  .out_o, .out_oe_n, .psel, .penable, .paddr, .pready, .pslverr);

// file: tb/doc_load.sv
`timescale 1ns/1ps
module doc_load (
  input wire clk, // system clock
  input wire out_o, // driven level
  input wire out_oe_n, // driver off when high
  output wire pin // level on the wire
);
  reg last_r = 1'h0;
  // no pull on the wire, so a floated pin shows a changing level
  assign pin = out_oe_n ? ~last_r : out_o;
  always @(posedge clk) begin
    last_r <= pin;
  end
endmodule // doc_load

// file: tb/divided_oscillator_output_control_bench.sv
`timescale 1ns/1ps
module divided_oscillator_output_control_bench;
  reg clk = 1'h0;
  reg reset = 1'h1;
  reg ce = 1'h1;
  reg oe_pin = 1'h1;
  reg psel = 1'h0;
  reg penable = 1'h0;
  reg pwrite = 1'h0;
  reg [7:0] div_sample = 8'h0f;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [31:0] rd;
  reg err;
  wire [31:0] prdata;
  wire out_o, out_oe_n, pready, pslverr, pin;
  integer fails = 0, num_checks = 0, n, k, len;
  always #25 clk = ~clk;
  doc_osc_out #(.STARTUP_MASTER(10), .MASTER_HALF_CLKS(2)) u_doc_osc_out (
    .clk, .reset, .ce, .div_sample, .oe_pin, .out_o, .out_oe_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  doc_load u_doc_load (.clk, .out_o, .out_oe_n, .pin);
  task report_and_stop;
    begin
      if (fails == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] e, input [31:0] g, input [63:0] nm);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("Error %0s exp %0h got %0h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      for (k = 0; pready !== 1'h1 && k < 50; k = k + 1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task hi_len;
    begin
      for (n = 0; pin !== 1'h0 && n < 999; n = n + 1) @(negedge clk);
      for (n = 0; pin !== 1'h1 && n < 999; n = n + 1) @(negedge clk);
      for (len = 0; pin === 1'h1 && len < 999; len = len + 1) @(negedge clk);
    end
  endtask
  task set_code(input [3:0] c, input [31:0] r, input [31:0] p);
    begin
      @(posedge clk);
      div_sample <= {c, c[0] ? 4'h0 : 4'hf};
      apb(0, 8'h08, 0);
      chk(p, rd, "hold");
      apb(0, 8'h04, 0);
      for (n = 0; rd[3:0] !== c && n < 400; n = n + 1) apb(0, 8'h04, 0);
      chk(c, rd[3:0], "newcode");
      apb(0, 8'h08, 0);
      chk(r, rd, "ratio");
    end
  endtask
  task t_start;
    begin
      repeat (30) @(negedge clk);
      chk(1, out_oe_n, "float");
      for (n = 0; out_oe_n !== 1'h0 && n < 400; n = n + 1) @(negedge clk);
      chk(0, out_oe_n, "start");
      chk(0, pin, "firstlow");
    end
  endtask
  task t_codes;
    integer c, r, p;
    begin
      p = 1;
      for (c = 1; c < 16; c = c + 1) begin
        r = c < 8 ? 1 << c : 1 << (15 - c);
        set_code(c[3:0], r, p);
        apb(0, 8'h04, 0);
        chk({c[3], c[3:0]}, rd[4:0], "code");
        hi_len;
        chk(2 * r, len, "half");
        p = r;
      end
    end
  endtask
  task t_oe;
    begin
      @(posedge clk);
      oe_pin <= 1'h0;
      @(negedge clk);
      chk(1, out_oe_n, "floated");
      set_code(7, 128, 1);
      chk(0, {out_oe_n, pin}, "held");
      @(posedge clk);
      oe_pin <= 1'h1;
      for (n = 0; pin !== 1'h1 && n < 99; n = n + 1) @(negedge clk);
      chk(1, n <= 8, "endelay");
    end
  endtask
  task t_ce;
    reg lv;
    begin
      @(posedge clk);
      ce <= 1'h0;
      @(negedge clk);
      lv = pin;
      repeat (20) @(negedge clk);
      chk(lv, pin, "frozen");
      @(posedge clk);
      ce <= 1'h1;
    end
  endtask
  task t_apb;
    begin
      hi_len;
      apb(1, 8'h00, 1);
      apb(0, 8'h00, 0);
      chk(1, rd, "ctrl");
      hi_len;
      chk(0, len, "forced");
      apb(1, 8'h00, 0);
      apb(1, 8'h0c, 32'hffffffff);
      chk(1, err, "slverr");
      apb(0, 8'h0c, 0);
      chk(2, {err, rd[0]}, "unmap");
    end
  endtask
  initial begin
    #3000000;
    fails = fails + 1;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    t_start;
    t_codes;
    t_oe;
    t_ce;
    t_apb;
    report_and_stop;
  end
endmodule // divided_oscillator_output_control_bench
